// [core/dsdp_strobe_cond.sv]
// Purpose: read strobe conditioning, capture polarity and write strobe transfer
// Assumes: strobe_clk_i is the pad strobe after the external delay element
// Notes: strobe domain logic only advances while the memory toggles the strobe
//
// Summary of operation
// - pad strobe goes through a delay element, then clocks the group's capture registers.
// - delay setting is a 6-bit code from one of two DLLs, chosen by half.
// - each DLL steps its code to track drift against the system clock.
// - the strobe also feeds the logic choosing the synchronizer clock polarity.
// - polarity selects the system edge for syncing; re-chosen at every read preamble.
// - a detector sees idle-to-low preamble transition and sets polarity from it.
// - a 90-degree write transfer signal goes to output registers across the bus.
// - the write shift delay makes transfer by shifting edge clock one 90 degrees.
// - core logic stays idle until core, config and aux supplies all report good.
// - until the core is active, user I/O stays high impedance with weak pull-up.
// - data captured on both strobe edges, then resynchronized to the system clock.
// - sync clock polarity selects which clock edge the synchronizing registers use.
`timescale 1ns/1ps
`default_nettype none
module dsdp_strobe_cond
	import dsdp_pkg::*;
(
	input wire logic mclk_i, // system clock, 125 MHz
	input wire logic rst_n_i, // synchronous reset, active low
	input wire logic strobe_clk_i, // delayed strobe, link clock
	input wire logic strobe_pad_i, // strobe pad level
	output logic strobe_pad_o, // strobe pad drive value
	output logic strobe_pad_oe_n_o, // strobe pad enable, low drives
	output logic io_pullup_o, // weak pull-up on user I/O
	input wire logic [DSDP_DQ_W-1:0] dq_i, // data pins of the group
	input wire logic vcc_ok_i, // core supply detector
	input wire logic vcccfg_ok_i, // configuration bank supply detector
	input wire logic vccaux_ok_i, // auxiliary supply detector
	output logic core_active_o, // power-on reset released
	input wire logic [DSDP_NUM_DLL-1:0] dll_lead_i, // dll phase detector, 1 lengthens
	output logic [DSDP_NUM_DLL-1:0][DSDP_CODE_W-1:0] dll_code_o, // dll calibration buses
	output logic [DSDP_NUM_DLL-1:0] dll_lock_o, // dll has reached lock
	input wire logic half_sel_i, // strap: which dll serves this group
	output logic [DSDP_CODE_W-1:0] strobe_delay_code_o, // delay element setting
	input wire logic read_en_i, // read window from the core
	input wire logic write_en_i, // write window from the core
	output logic sync_clock_polarity_o, // 1: sync on falling system edge
	output logic read_armed_o, // waiting for preamble
	output logic capture_ready_o, // fifo room, strobe domain
	output logic [DSDP_WORD_W-1:0] rd_data_o, // {falling, rising} data word
	output logic rd_valid_o, // rd_data_o is valid
	input wire logic rd_ready_i, // core takes the word
	output logic edge_clock_one_o, // edge clock, quarter rate
	output logic write_strobe_transfer_o // edge clock one shifted 90 degrees
);
	// supply detector synchronizers
	logic [2:0] sup_s1_q, sup_s2_q;
	logic core_active_q;
	// strobe pad level, synced on both system edges
	logic pad_p1_q, pad_p2_q, pad_n1_q, pad_n2_q;
	logic seen_idle_q;
	dsdp_rd_e rd_state_q, rd_state_d;
	dsdp_pol_e pol_q, pol_d;
	// dll state
	logic [DSDP_NUM_DLL-1:0] lead_s1_q, lead_s2_q, last_dir_q;
	logic [DSDP_UPD_CNT_W-1:0] upd_cnt_q;
	logic half_s1_q, half_s2_q;
	logic [DSDP_CODE_W-1:0] dly_code_q;
	// write transfer
	logic [DSDP_ECLK_W-1:0] ecnt_q;
	logic eclk_q, xfer_q, wr_drive_q;
	// strobe domain
	logic srst_s1_q, srst_s2_q;
	logic [DSDP_DQ_W-1:0] rise_q;

	// power-on release needs all three detectors
	wire supplies_ok = &sup_s2_q;
	wire upd_tick = (upd_cnt_q == DSDP_UPD_LAST);
	// preamble: idle level was seen, now either edge chain reports low
	wire pad_low_seen = !pad_p2_q || !pad_n2_q;
	wire preamble_hit = (rd_state_q == DSDP_RD_ARMED) && seen_idle_q && pad_low_seen;
	// falling chain saw the low first: the edge fell in the first half cycle
	wire pol_from_pad = !pad_n2_q && pad_p2_q;
	wire fall_clk = ~strobe_clk_i;
	wire [DSDP_WORD_W-1:0] cap_word = {dq_i, rise_q};

	// supply detectors come from analog, so two flops first
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			sup_s1_q <= '0;
			sup_s2_q <= '0;
		end else begin
			sup_s1_q <= {vcc_ok_i, vcccfg_ok_i, vccaux_ok_i};
			sup_s2_q <= sup_s1_q;
		end
	end

	// core active only while every supply stays good
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			core_active_q <= 1'b0;
		end else begin
			core_active_q <= supplies_ok;
		end
	end

	// pad level sync on the rising system edge
	always_ff @(posedge mclk_i) begin
		if (!core_active_q) begin
			pad_p1_q <= 1'b1;
			pad_p2_q <= 1'b1;
		end else begin
			pad_p1_q <= strobe_pad_i;
			pad_p2_q <= pad_p1_q;
		end
	end

	// pad level sync on the falling edge, gives half-cycle resolution
	always_ff @(negedge mclk_i) begin
		if (!core_active_q) begin
			pad_n1_q <= 1'b1;
			pad_n2_q <= 1'b1;
		end else begin
			pad_n1_q <= strobe_pad_i;
			pad_n2_q <= pad_n1_q;
		end
	end

	// read tracking: arm on read start, fix polarity at preamble, release at end
	always_comb begin
		rd_state_d = rd_state_q;
		pol_d = pol_q;
		case (rd_state_q)
			DSDP_RD_IDLE: begin
				if (read_en_i) begin
					rd_state_d = DSDP_RD_ARMED;
				end
			end
			DSDP_RD_ARMED: begin
				if (!read_en_i) begin
					rd_state_d = DSDP_RD_IDLE;
				end else if (preamble_hit) begin
					rd_state_d = DSDP_RD_HELD;
					pol_d = pol_from_pad ? DSDP_POL_FALL : DSDP_POL_RISE;
				end
			end
			DSDP_RD_HELD: begin
				if (!read_en_i) begin
					rd_state_d = DSDP_RD_IDLE; // polarity untouched here
				end
			end
			default: begin
				rd_state_d = DSDP_RD_IDLE;
			end
		endcase
	end

	// state and polarity registers
	always_ff @(posedge mclk_i) begin
		if (!core_active_q) begin
			rd_state_q <= DSDP_RD_IDLE;
			pol_q <= DSDP_POL_RISE;
		end else begin
			rd_state_q <= rd_state_d;
			pol_q <= pol_d;
		end
	end

	// the memory floats the strobe first; a low left over is not a preamble
	always_ff @(posedge mclk_i) begin
		if (!core_active_q || rd_state_q != DSDP_RD_ARMED) begin
			seen_idle_q <= 1'b0;
		end else if (pad_p2_q && pad_n2_q) begin
			seen_idle_q <= 1'b1;
		end
	end

	// shared update tick for both dlls
	always_ff @(posedge mclk_i) begin
		if (!core_active_q || upd_tick) begin
			upd_cnt_q <= '0;
		end else begin
			upd_cnt_q <= upd_cnt_q + 1'b1;
		end
	end

	// one calibration loop per dll
	genvar g;
	generate
		for (g = 0; g < DSDP_NUM_DLL; g++) begin : g_dll
			logic [DSDP_CODE_W-1:0] code_q;
			logic lock_q;
			wire at_max = (code_q == DSDP_CODE_MAX);
			wire at_min = (code_q == DSDP_CODE_MIN);
			// phase detector output is asynchronous
			always_ff @(posedge mclk_i) begin
				if (!core_active_q) begin
					lead_s1_q[g] <= 1'b0;
					lead_s2_q[g] <= 1'b0;
				end else begin
					lead_s1_q[g] <= dll_lead_i[g];
					lead_s2_q[g] <= lead_s1_q[g];
				end
			end
			// saturating step; a direction change means the loop dithers at lock
			always_ff @(posedge mclk_i) begin
				if (!core_active_q) begin
					code_q <= DSDP_CODE_RST;
					lock_q <= 1'b0;
					last_dir_q[g] <= 1'b0;
				end else if (upd_tick) begin
					if (lead_s2_q[g] && !at_max) begin
						code_q <= code_q + 1'b1;
					end else if (!lead_s2_q[g] && !at_min) begin
						code_q <= code_q - 1'b1;
					end
					last_dir_q[g] <= lead_s2_q[g];
					if (last_dir_q[g] != lead_s2_q[g]) begin
						lock_q <= 1'b1;
					end
				end
			end
			assign dll_code_o[g] = code_q;
			assign dll_lock_o[g] = lock_q;
		end
	endgenerate

	// half strap is a pin, so it passes two flops too
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			half_s1_q <= 1'b0;
			half_s2_q <= 1'b0;
		end else begin
			half_s1_q <= half_sel_i;
			half_s2_q <= half_s1_q;
		end
	end

	// delay element follows the dll of this group's half
	always_ff @(posedge mclk_i) begin
		if (!core_active_q) begin
			dly_code_q <= DSDP_CODE_RST;
		end else begin
			dly_code_q <= half_s2_q ? dll_code_o[1] : dll_code_o[0];
		end
	end

	// edge clock one and its quarter-period (90 degree) shifted copy
	always_ff @(posedge mclk_i) begin
		if (!core_active_q) begin
			ecnt_q <= '0;
			eclk_q <= 1'b0;
			xfer_q <= 1'b0;
			wr_drive_q <= 1'b0;
		end else begin
			ecnt_q <= ecnt_q + 1'b1;
			eclk_q <= ecnt_q[DSDP_ECLK_W-1];
			xfer_q <= eclk_q; // lags edge clock one by a quarter period
			wr_drive_q <= write_en_i;
		end
	end

	// strobe domain reset: clears at once, releases after two strobe edges
	// the strobe is stopped outside bursts, so a synchronous clear would never land
	always_ff @(posedge strobe_clk_i or negedge core_active_q) begin
		if (!core_active_q) begin
			srst_s1_q <= 1'b0;
			srst_s2_q <= 1'b0;
		end else begin
			srst_s1_q <= 1'b1;
			srst_s2_q <= srst_s1_q;
		end
	end

	// rising strobe edge capture; falling half is stored by the fifo write
	always_ff @(posedge strobe_clk_i) begin
		if (!srst_s2_q) begin
			rise_q <= '0;
		end else begin
			rise_q <= dq_i;
		end
	end

	// falling-edge word write and resync into the system domain
	dsdp_fifo #(
		.W(DSDP_WORD_W),
		.AW(DSDP_FIFO_AW)
	) u_fifo (
		.wclk_i(fall_clk),
		.wrst_n_i(srst_s2_q),
		.w_valid_i(srst_s2_q),
		.w_ready_o(capture_ready_o),
		.w_data_i(cap_word),
		.rclk_i(mclk_i),
		.rrst_n_i(core_active_q),
		.r_pol_i(pol_q),
		.r_valid_o(rd_valid_o),
		.r_ready_i(rd_ready_i),
		.r_data_o(rd_data_o)
	);

	// pad and status outputs; pins float with pull-up until core active
	assign strobe_pad_oe_n_o = !(core_active_q && wr_drive_q);
	assign io_pullup_o = !core_active_q;
	assign strobe_pad_o = xfer_q;
	assign write_strobe_transfer_o = xfer_q;
	assign edge_clock_one_o = eclk_q;
	assign core_active_o = core_active_q;
	assign strobe_delay_code_o = dly_code_q;
	assign sync_clock_polarity_o = pol_q;
	assign read_armed_o = (rd_state_q == DSDP_RD_ARMED);
endmodule
`default_nettype wire

// [inc/dsdp_pkg.sv]
// Purpose: shared constants and types for the strobe delay and polarity block
// Assumes: system clock of 125 MHz, one data group of eight lines
// Notes: the shared widths, the dll code reset value and the timing counts live here
package dsdp_pkg;
	// data group and calibration widths
	localparam int DSDP_DQ_W = 8;
	localparam int DSDP_WORD_W = 2 * DSDP_DQ_W;
	localparam int DSDP_CODE_W = 6;
	localparam int DSDP_NUM_DLL = 2;
	localparam int DSDP_FIFO_DEPTH = 8;
	localparam int DSDP_FIFO_AW = 3;
	// calibration code limits and start point
	localparam logic [DSDP_CODE_W-1:0] DSDP_CODE_RST = 6'h20;
	localparam logic [DSDP_CODE_W-1:0] DSDP_CODE_MAX = 6'h3f;
	localparam logic [DSDP_CODE_W-1:0] DSDP_CODE_MIN = 6'h00;
	// timing: dll update interval in ns, converted to whole system clock cycles
	localparam int DSDP_CLK_MHZ = 125;
	localparam int DSDP_DLL_UPD_NS = 64;
	localparam int DSDP_DLL_UPD_CYC = (DSDP_DLL_UPD_NS * DSDP_CLK_MHZ) / 1000;
	localparam int DSDP_UPD_CNT_W = 4;
	localparam logic [DSDP_UPD_CNT_W-1:0] DSDP_UPD_LAST = 4'(DSDP_DLL_UPD_CYC - 1);
	// edge clock divider width (edge clock is a quarter of the system clock)
	localparam int DSDP_ECLK_W = 2;
	// polarity of the clock that feeds the synchronizing registers
	typedef enum logic {
		DSDP_POL_RISE = 1'b0,
		DSDP_POL_FALL = 1'b1
	} dsdp_pol_e;
	// read tracking states
	typedef enum logic [1:0] {
		DSDP_RD_IDLE = 2'b00,
		DSDP_RD_ARMED = 2'b01,
		DSDP_RD_HELD = 2'b10
	} dsdp_rd_e;
endpackage

// [core/dsdp_fifo.sv]
// Purpose: dual-clock fifo moving captured strobe words into the system clock
// Assumes: write clock may stop between bursts; read clock runs free
// Notes: gray pointers; the read side syncs the write pointer on either clock edge
// Notes: write side clears asynchronously, its clock may not run during reset
`timescale 1ns/1ps
`default_nettype none
module dsdp_fifo #(
	parameter int W = 16,
	parameter int AW = 3
) (
	input wire logic wclk_i, // strobe-side write clock
	input wire logic wrst_n_i, // write-side reset, active low
	input wire logic w_valid_i, // word offered
	output logic w_ready_o, // room for a word
	input wire logic [W-1:0] w_data_i, // word to store
	input wire logic rclk_i, // system clock
	input wire logic rrst_n_i, // read-side reset, active low
	input wire logic r_pol_i, // 1: sync pointer on falling edge
	output logic r_valid_o, // output word valid
	input wire logic r_ready_i, // consumer takes word
	output logic [W-1:0] r_data_o // registered output word
);
	logic [W-1:0] mem_q [2**AW];
	logic [AW:0] wbin_q, wgray_q, rbin_q, rgray_q;
	logic [AW:0] rg_s1_q, rg_s2_q, wgp_s1_q, wgp_s2_q, wgn_s1_q, wgn_s2_q;
	logic [AW:0] wbin_d, rbin_d, wgray_sel;
	logic [W-1:0] r_data_q;
	logic r_valid_q;
	wire push = w_valid_i && w_ready_o;
	wire empty = (rgray_q == wgray_sel);
	wire pop = !empty && (!r_valid_q || r_ready_i);
	// full when write gray equals read gray with top two bits inverted
	assign w_ready_o = (wgray_q != {~rg_s2_q[AW:AW-1], rg_s2_q[AW-2:0]});
	assign wbin_d = wbin_q + (AW+1)'(push);
	assign rbin_d = rbin_q + (AW+1)'(pop);
	// chosen polarity decides which sync chain the read side trusts
	assign wgray_sel = r_pol_i ? wgn_s2_q : wgp_s2_q;
	assign r_valid_o = r_valid_q;
	assign r_data_o = r_data_q;
	// write side: memory
	always_ff @(posedge wclk_i) begin
		if (push) begin
			mem_q[wbin_q[AW-1:0]] <= w_data_i;
		end
	end
	// write pointer, so the read side never syncs an unknown pointer
	always_ff @(posedge wclk_i or negedge wrst_n_i) begin
		if (!wrst_n_i) begin
			wbin_q <= '0;
			wgray_q <= '0;
		end else begin
			wbin_q <= wbin_d;
			wgray_q <= wbin_d ^ (wbin_d >> 1);
		end
	end
	// read pointer into the write domain, two flops
	always_ff @(posedge wclk_i or negedge wrst_n_i) begin
		if (!wrst_n_i) begin
			rg_s1_q <= '0;
			rg_s2_q <= '0;
		end else begin
			rg_s1_q <= rgray_q;
			rg_s2_q <= rg_s1_q;
		end
	end
	// write pointer sync on the rising system edge
	always_ff @(posedge rclk_i) begin
		if (!rrst_n_i) begin
			wgp_s1_q <= '0;
			wgp_s2_q <= '0;
		end else begin
			wgp_s1_q <= wgray_q;
			wgp_s2_q <= wgp_s1_q;
		end
	end
	// same sync on the falling system edge, for the opposite polarity
	always_ff @(negedge rclk_i) begin
		if (!rrst_n_i) begin
			wgn_s1_q <= '0;
			wgn_s2_q <= '0;
		end else begin
			wgn_s1_q <= wgray_q;
			wgn_s2_q <= wgn_s1_q;
		end
	end
	// read side: registered show-ahead output stage
	always_ff @(posedge rclk_i) begin
		if (!rrst_n_i) begin
			rbin_q <= '0;
			rgray_q <= '0;
			r_valid_q <= 1'b0;
			r_data_q <= '0;
		end else begin
			rbin_q <= rbin_d;
			rgray_q <= rbin_d ^ (rbin_d >> 1);
			if (pop) begin
				r_data_q <= mem_q[rbin_q[AW-1:0]];
				r_valid_q <= 1'b1;
			end else if (r_ready_i) begin
				r_valid_q <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// [dv/dsdp_strobe_cond_props.sv]
// Purpose: port-level checks for the strobe conditioning block
// Assumes: bound onto dsdp_strobe_cond
// Notes: most checks sleep while the core is held inactive, since all state they check resets then
`timescale 1ns/1ps
`default_nettype none
module dsdp_strobe_cond_props
	import dsdp_pkg::*;
(
	input wire logic mclk_i, // system clock
	input wire logic rst_n_i, // reset, active low
	input wire logic vcc_ok_i, // core supply
	input wire logic vcccfg_ok_i, // config supply
	input wire logic vccaux_ok_i, // aux supply
	input wire logic core_active_o, // por released
	input wire logic io_pullup_o, // weak pull-up
	input wire logic strobe_pad_oe_n_o, // pad enable
	input wire logic write_en_i, // write window
	input wire logic read_en_i, // read window
	input wire logic strobe_pad_i, // pad level
	input wire logic read_armed_o, // awaiting preamble
	input wire logic sync_clock_polarity_o, // sync edge
	input wire logic edge_clock_one_o, // edge clock
	input wire logic write_strobe_transfer_o, // shifted edge clock
	input wire logic half_sel_i, // dll select
	input wire logic [DSDP_NUM_DLL-1:0][DSDP_CODE_W-1:0] dll_code_o, // dll codes
	input wire logic [DSDP_CODE_W-1:0] strobe_delay_code_o // delay code
);
	// all three supplies good
	wire logic ok_all = vcc_ok_i & vcccfg_ok_i & vccaux_ok_i;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i || !core_active_o);
	// edge clock: two high, two low
	sequence s_eclk; edge_clock_one_o[*2] ##1 !edge_clock_one_o[*2]; endsequence
	// idle high seen while armed, then a held-low preamble
	sequence s_pre; (read_armed_o && strobe_pad_i)[*3] ##1 !strobe_pad_i[*5]; endsequence
	property p_por; disable iff (!rst_n_i) core_active_o |-> $past(ok_all, 3); endproperty
	a_por: assert property (p_por) else $error("core active without supplies");
	property p_pull; disable iff (!rst_n_i) !core_active_o |-> io_pullup_o && strobe_pad_oe_n_o; endproperty
	a_pull: assert property (p_pull) else $error("pad not floating with pull-up");
	property p_oe; !strobe_pad_oe_n_o |-> $past(write_en_i); endproperty
	a_oe: assert property (p_oe) else $error("pad driven outside write");
	property p_oe_on; $past(write_en_i) && $past(core_active_o) |-> !strobe_pad_oe_n_o; endproperty
	a_oe_on: assert property (p_oe_on) else $error("pad not driven in write");
	property p_eclk; $rose(edge_clock_one_o) |-> s_eclk ##1 edge_clock_one_o; endproperty
	a_eclk: assert property (p_eclk) else $error("edge clock period wrong");
	property p_xfer; $past(core_active_o) |-> write_strobe_transfer_o == $past(edge_clock_one_o); endproperty
	a_xfer: assert property (p_xfer) else $error("transfer not a quarter behind");
	property p_sel;
		$past(half_sel_i, 3) == half_sel_i && $past(half_sel_i, 2) == half_sel_i && $past(half_sel_i) == half_sel_i
		|-> strobe_delay_code_o == $past(dll_code_o[half_sel_i]);
	endproperty
	a_sel: assert property (p_sel) else $error("delay code from wrong dll");
	property p_gap; $changed(dll_code_o[0]) |=> $stable(dll_code_o[0])[*7]; endproperty
	a_gap: assert property (p_gap) else $error("dll stepped too soon");
	property p_step;
		$changed(dll_code_o[1]) |-> (dll_code_o[1] - $past(dll_code_o[1])) == 6'h01
			|| ($past(dll_code_o[1]) - dll_code_o[1]) == 6'h01;
	endproperty
	a_step: assert property (p_step) else $error("dll step not one");
	property p_arm; read_en_i && !$past(read_en_i) && !read_armed_o |=> read_armed_o; endproperty
	a_arm: assert property (p_arm) else $error("read did not arm");
	property p_det; read_en_i throughout s_pre |=> !read_armed_o; endproperty
	a_det: assert property (p_det) else $error("preamble not detected");
	property p_hold; $changed(sync_clock_polarity_o) |-> $past(read_armed_o) || $past(read_armed_o, 2); endproperty
	a_hold: assert property (p_hold) else $error("polarity moved mid read");
endmodule
`default_nettype wire

// [dv/dsdp_mem_model.sv]
// Purpose: behavioural memory driving the read strobe and data
// Assumes: one burst per rising go_i
// Notes: strobe clock stands low outside bursts; released data shows inverted
`timescale 1ns/1ps
`default_nettype none
module dsdp_mem_model (
	input wire logic go_i, // start a burst
	input wire logic slow_i, // longer idle lead-in
	input wire logic [7:0] base_i, // first data byte
	input wire logic [3:0] words_i, // words in burst
	output logic drv_o, // memory drives strobe pad
	output logic lvl_o, // strobe level when driven
	output logic strobe_clk_o, // delayed strobe
	output logic [7:0] dq_o, // data pins
	output logic busy_o // burst running
);
	// idle, preamble low, toggling strobe, release
	always @(posedge go_i) begin
		busy_o = 1'b1;
		#(slow_i ? 64 : 32);
		drv_o = 1'b1;
		lvl_o = 1'b0;
		#40;
		for (int k = 0; k < 2 * words_i; k++) begin
			dq_o = base_i + 8'(k);
			#3 strobe_clk_o = ~strobe_clk_o;
			lvl_o = strobe_clk_o;
			#3;
		end
		#6 drv_o = 1'b0; // termination takes the pad high
		dq_o = ~dq_o;
		busy_o = 1'b0;
	end
	// lines idle at time zero
	initial begin
		drv_o = 1'b0;
		lvl_o = 1'b1;
		strobe_clk_o = 1'b0;
		dq_o = 8'h5a;
		busy_o = 1'b0;
	end
endmodule
`default_nettype wire

// [dv/ddr_strobe_delay_polarity_test.sv]
// Purpose: self-checking bench for the strobe conditioning block
// Assumes: memory model on the read side, 12 ns strobe
// Notes: first burst after power-up is flushed, the strobe reset sync eats words
`timescale 1ns/1ps
`default_nettype none
module ddr_strobe_delay_polarity_test;
	import dsdp_pkg::*;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [2:0] ok = 3'b011;
	logic [1:0] lead = 2'b00;
	logic half = 1'b0, rd_en = 1'b0, wr_en = 1'b0, rdy = 1'b0, go = 1'b0, slow = 1'b0;
	logic stall = 1'b0, fixl = 1'b0, flush = 1'b1;
	logic [7:0] base = 8'h00;
	logic [3:0] words = 4'h0;
	logic [31:0] seed = 32'h34ddeb81;
	logic [15:0] exp_q[$];
	int offs[6] = '{1, 2, 3, 5, 6, 7};
	int error_cnt = 0;
	int comparisons = 0;
	wire logic pad_o, oe_n, pull, act, pol, armed, crdy, rvalid, eclk, xfer, drv, lvl, sclk, busy;
	wire logic [7:0] dq;
	wire logic [15:0] rdata;
	wire logic [1:0][5:0] code;
	wire logic [5:0] dcode;
	wire logic [1:0] lock;
	// block drives in writes, memory in reads, termination otherwise
	wire logic pad = !oe_n ? pad_o : (drv ? lvl : 1'b1);
	dsdp_strobe_cond u_dsdp_strobe_cond (
		.mclk_i(mclk), .rst_n_i(rst_n), .strobe_clk_i(sclk), .strobe_pad_i(pad), .strobe_pad_o(pad_o),
		.strobe_pad_oe_n_o(oe_n), .io_pullup_o(pull), .dq_i(dq), .vcc_ok_i(ok[0]), .vcccfg_ok_i(ok[1]),
		.vccaux_ok_i(ok[2]), .core_active_o(act), .dll_lead_i(lead), .dll_code_o(code), .dll_lock_o(lock),
		.half_sel_i(half), .strobe_delay_code_o(dcode), .read_en_i(rd_en), .write_en_i(wr_en),
		.sync_clock_polarity_o(pol), .read_armed_o(armed), .capture_ready_o(crdy), .rd_data_o(rdata),
		.rd_valid_o(rvalid), .rd_ready_i(rdy), .edge_clock_one_o(eclk), .write_strobe_transfer_o(xfer)
	);
	dsdp_mem_model u_dsdp_mem_model (.go_i(go), .slow_i(slow), .base_i(base), .words_i(words),
		.drv_o(drv), .lvl_o(lvl), .strobe_clk_o(sclk), .dq_o(dq), .busy_o(busy));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	initial forever #4 mclk = ~mclk;
	// ready and dll phase wander under the shift register
	always @(posedge mclk) begin
		#1;
		seed = lfsr(seed);
		rdy = !stall && seed[0];
		lead = fixl ? 2'b01 : seed[2:1];
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic summarize();
		if (error_cnt == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// each accepted word is matched to the oldest note
	always @(posedge mclk)
		if (rvalid === 1'b1 && rdy && !flush) begin
			if (exp_q.size() > 0)
				chk(rdata, exp_q.pop_front());
			else
				chk(rdata, ~rdata);
		end
	// off picks the pad fall phase against mclk; kept words are the ones expected back
	task automatic rd_burst(input int off, input int n, input int kept);
		@(posedge mclk);
		#1 rd_en = 1'b1;
		base = seed[15:8];
		words = 4'(n);
		slow = off[0];
		for (int i = 0; i < kept; i++)
			exp_q.push_back({base + 8'(2 * i + 1), base + 8'(2 * i)});
		@(posedge mclk);
		#(off) go = 1'b1;
		repeat (2) @(posedge mclk);
		for (int i = 0; i < 60 && busy; i++)
			@(posedge mclk);
		chk(16'(busy), 16'h0000);
		chk(16'(pol), 16'(off < 4));
		#1 rd_en = 1'b0;
		go = 1'b0;
	endtask
	task automatic drain();
		for (int i = 0; i < 100 && exp_q.size() > 0; i++)
			@(posedge mclk);
		chk(16'(exp_q.size()), 16'h0000);
	endtask
	initial begin
		repeat (4) @(posedge mclk);
		#1 rst_n = 1'b1;
		repeat (10) @(posedge mclk);
		chk({act, pull}, 2'b01);
		#1 ok = 3'b111;
		repeat (5) @(posedge mclk);
		chk({act, pull}, 2'b10);
		rd_burst(1, 4, 0);
		repeat (40) @(posedge mclk);
		#1 flush = 1'b0;
		foreach (offs[j])
			rd_burst(offs[j], 3, 3);
		drain();
		stall = 1'b1;
		// eight words in memory plus one held in the output register
		rd_burst(2, 10, 9);
		chk(16'(crdy), 16'h0000);
		stall = 1'b0;
		drain();
		#1 wr_en = 1'b1;
		repeat (12) @(posedge mclk);
		chk(16'(oe_n), 16'h0000);
		repeat (12) @(posedge mclk);
		#1 wr_en = 1'b0;
		fixl = 1'b1;
		// enough updates to walk a code across the full range
		repeat (520) @(posedge mclk);
		chk(16'(code), 16'h003f);
		chk(16'(lock), 16'h0003);
		chk(16'(dcode), 16'h003f);
		#1 half = 1'b1;
		repeat (6) @(posedge mclk);
		chk(16'(dcode), 16'h0000);
		#1 ok = 3'b101;
		repeat (5) @(posedge mclk);
		chk({act, pull, oe_n}, 3'b011);
		chk(16'(code), 16'h0820);
		chk(16'(lock), 16'h0000);
		summarize();
	end
endmodule
bind dsdp_strobe_cond dsdp_strobe_cond_props u_dsdp_strobe_cond_props (.mclk_i, .rst_n_i, .vcc_ok_i,
	.vcccfg_ok_i, .vccaux_ok_i, .core_active_o, .io_pullup_o, .strobe_pad_oe_n_o, .write_en_i, .read_en_i,
	.strobe_pad_i, .read_armed_o, .sync_clock_polarity_o, .edge_clock_one_o, .write_strobe_transfer_o,
	.half_sel_i, .dll_code_o, .strobe_delay_code_o);
`default_nettype wire
